//--- bench/lsw_bench.sv
`timescale 1ns/100ps
`include "lsw_consts.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end

module lsw_bench;
    import lsw_pkg::*;
    localparam int unsigned BRK = 100;
    localparam int unsigned WTX = 50;
    localparam logic [23:0] ROWS [12] = '{24'h00a5a5, 24'h075a5a,
        24'h043c3c, 24'h0b8f8f, 24'h0c1212, 24'h0de7e7, 24'h0e1111,
        24'h09ff00, 24'h0aff00, 24'h0fff00, 24'h80ff00, 24'h01c3c3};
    logic       sys_clk, rst, sfr_wr, sfr_rd, send_break, send_wake;
    logic [7:0] sfr_addr;
    lsw_byte_t  sfr_wdata, sfr_rdata, v;
    logic       irq, busy, break_seen, wake_seen;
    int         errors, cmp_count, cyc, k, i, nw, nb, w0;

    lsw_if lin_bus ();
    lsw_device #(.IDLE_CYC(2000), .WAKE_RESP_CYC(1000), .BREAK_CYC(BRK),
        .WAKE_TX_CYC(WTX), .WAKE_DET_CYC(30)) u_lsw_device (
        .sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .irq(irq), .lin(lin_bus));
    lsw_node #(.BREAK_CYC(BRK), .WAKE_TX_CYC(WTX), .WAKE_DET_CYC(30))
        u_lsw_node (.sys_clk(sys_clk), .rst(rst), .send_break(send_break),
        .send_wake(send_wake), .busy(busy), .break_seen(break_seen),
        .wake_seen(wake_seen), .lin(lin_bus));
    lsw_sva #(.BREAK_CYC(BRK), .WAKE_TX_CYC(WTX)) u_lsw_sva (
        .sys_clk(sys_clk), .rst(rst), .dev_out(lin_bus.dev_out),
        .dev_oe(lin_bus.dev_oe), .node_out(lin_bus.node_out),
        .node_oe(lin_bus.node_oe), .bus(lin_bus.bus));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Cycle count, hang limit and node event counts
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        nw <= nw + int'(wake_seen === 1'b1);
        nb <= nb + int'(break_seen === 1'b1);
        if (cyc == 20000) begin
            errors++;
            stop_test();
        end
    end

    task automatic wr(input logic [7:0] a, input lsw_byte_t d);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output lsw_byte_t d);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
        @(negedge sys_clk);
        d = sfr_rdata;
    endtask : rd

    task automatic wi(input logic [7:0] a, input lsw_byte_t d);
        wr(`LSW_SFR_ADR, a);
        wr(`LSW_SFR_DAT, d);
    endtask : wi

    task automatic ri(input logic [7:0] a, output lsw_byte_t d);
        wr(`LSW_SFR_ADR, a);
        rd(`LSW_SFR_DAT, d);
    endtask : ri

    task automatic np(input bit b);
        @(posedge sys_clk);
        send_break <= b;
        send_wake <= !b;
        @(posedge sys_clk);
        send_break <= 1'b0;
        send_wake <= 1'b0;
    endtask : np

    function automatic logic hit(input int s);
        return s == 0 ? irq : s == 1 ? lin_bus.dev_oe : !lin_bus.dev_oe;
    endfunction : hit

    // Waits at falling edges for a condition, counting the cycles
    task automatic wt(input int s, input int n, output int c);
        for (c = 0; c < n && hit(s) !== 1'b1; c++) @(negedge sys_clk);
        `CHK("wait", 1'b1, hit(s))
    endtask : wt

    task automatic stop_test();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test

    initial begin
        {rst, sfr_wr, sfr_rd, send_break, send_wake} = 5'h10;
        {sfr_addr, sfr_wdata} = 16'h0000;
        {errors, cmp_count, cyc, nw, nb} = 160'h0;
        repeat (10) @(posedge sys_clk);
        `CHK("rdata_rst", 8'h00, sfr_rdata)
        `CHK("irq_rst", 1'b0, irq)
        rst <= 1'b0;
        rd(`LSW_SFR_CF, v);
        `CHK("cfg_rst", 8'h60, v)
        rd(`LSW_SFR_ADR, v);
        `CHK("ptr_rst", 8'h00, v)
        for (i = 0; i < 12; i++) begin
            wi(ROWS[i][23:16], ROWS[i][15:8]);
            ri(ROWS[i][23:16], v);
            `CHK("core", ROWS[i][7:0], v)
        end
        rd(`LSW_SFR_ADR, v);
        `CHK("ptr", 8'h01, v)
        wr(`LSW_SFR_CF, 8'hff);
        rd(`LSW_SFR_CF, v);
        `CHK("cfg_low", 8'he0, v)
        wr(`LSW_SFR_CF, 8'h80);
        rd(`LSW_SFR_CF, v);
        `CHK("cfg_slave", 8'h80, v)
        np(1'b0);
        @(negedge sys_clk);
        `CHK("node_busy", 1'b1, busy)
        wt(0, 200, k);
        ri(`LSW_CORE_ST, v);
        `CHK("st_wake", 8'h0b, v & 8'h0b)
        wi(`LSW_CORE_CTRL, 8'h08);
        ri(`LSW_CORE_CTRL, v);
        `CHK("ctrl_rd", 8'h00, v)
        `CHK("irq_clr", 1'b0, irq)
        np(1'b1);
        wt(0, 300, k);
        wi(`LSW_CORE_CTRL, 8'h88);
        np(1'b0);
        repeat (100) @(negedge sys_clk);
        `CHK("stopped", 1'b0, irq)
        np(1'b1);
        wt(0, 300, k);
        ri(`LSW_CORE_ST, v);
        `CHK("st_pend", 8'h18, v & 8'h18)
        wi(`LSW_CORE_CTRL, 8'h18);
        ri(`LSW_CORE_CTRL, v);
        `CHK("ack_clr", 8'h00, v)
        w0 = nw;
        wi(`LSW_CORE_CTRL, 8'h02);
        wt(1, 5, k);
        wt(2, 200, k);
        repeat (3) @(negedge sys_clk);
        `CHK("node_wake", 1'b1, nw > w0)
        `CHK("slv_noirq", 1'b0, irq)
        wt(0, 1100, k);
        ri(`LSW_CORE_ERR, v);
        `CHK("err_timeout_fault", 8'h04, v)
        ri(`LSW_CORE_ST, v);
        `CHK("st_err", 8'h0c, v & 8'h0c)
        wi(`LSW_CORE_CTRL, 8'h02);
        repeat (20) @(negedge sys_clk);
        `CHK("refused", 1'b0, lin_bus.dev_oe)
        ri(`LSW_CORE_CTRL, v);
        `CHK("req_clr", 8'h00, v)
        wi(`LSW_CORE_CTRL, 8'h0c);
        ri(`LSW_CORE_ERR, v);
        `CHK("err_clr", 8'h00, v)
        ri(`LSW_CORE_ST, v);
        `CHK("st_clr", 8'h00, v & 8'h0c)
        wt(0, 2100, k);
        ri(`LSW_CORE_ST, v);
        `CHK("idle", 8'h48, v & 8'h48)
        wi(`LSW_CORE_CTRL, 8'h48);
        ri(`LSW_CORE_CTRL, v);
        `CHK("sleep_set", 8'h40, v)
        repeat (2100) @(negedge sys_clk);
        `CHK("sleep_quiet", 1'b0, irq)
        np(1'b0);
        wt(0, 200, k);
        wi(`LSW_CORE_CTRL, 8'h08);
        ri(`LSW_CORE_CTRL, v);
        `CHK("sleep_clr", 8'h00, v)
        wr(`LSW_SFR_CF, 8'hc0);
        wi(`LSW_CORE_CTRL, 8'h0a);
        wt(1, 5, k);
        wt(2, 200, k);
        `CHK("wake_len", WTX, k)
        wt(0, 5, k);
        ri(`LSW_CORE_ST, v);
        `CHK("st_done", 8'h09, v & 8'h09)
        for (i = 0; i < 2; i++) begin
            wr(`LSW_SFR_CF, 8'hc0);
            wi(`LSW_CORE_SIZE, 8'h00);
            wi(`LSW_CORE_CTRL, 8'h09);
            wt(1, 5, k);
            repeat (8) @(negedge sys_clk);
            if (i == 0) wr(`LSW_SFR_CF, 8'h80);
            else wi(`LSW_CORE_SIZE, 8'h80);
            repeat (3) @(negedge sys_clk);
            `CHK("dropped", 1'b0, lin_bus.dev_oe)
        end
        w0 = nb;
        wi(`LSW_CORE_CTRL, 8'h09);
        wt(1, 5, k);
        wt(2, 200, k);
        `CHK("brk_len", BRK, k)
        repeat (3) @(negedge sys_clk);
        `CHK("node_brk", 1'b1, nb > w0)
        ri(`LSW_CORE_ST, v);
        `CHK("st_brk", 8'h09, v & 8'h09)
        stop_test();
    end
endmodule : lsw_bench

//--- bench/lsw_sva.sv
`timescale 1ns/100ps

// ============================================================
// Wire checks on the link joining the two ends
module lsw_sva #(
    parameter int unsigned BREAK_CYC   = 100,
    parameter int unsigned WAKE_TX_CYC = 50
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic dev_out,
    input wire logic dev_oe,
    input wire logic node_out,
    input wire logic node_oe,
    input wire logic bus
);
    int unsigned dev_run_q;
    int unsigned node_run_q;

    // Length of the current dominant drive of each end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) dev_run_q <= 0;
        else dev_run_q <= dev_oe ? dev_run_q + 1 : 0;
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) node_run_q <= 0;
        else node_run_q <= node_oe ? node_run_q + 1 : 0;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence dev_start_s;
        $rose(dev_oe);
    endsequence
    sequence node_start_s;
        $rose(node_oe);
    endsequence
    sequence node_end_s;
        $fell(node_oe);
    endsequence

    dev_low_a: assert property (dev_oe |-> !dev_out && !bus)
        else $error("device drive not dominant");
    node_low_a: assert property (node_oe |-> !node_out && !bus)
        else $error("node drive not dominant");
    idle_high_a: assert property (!dev_oe && !node_oe |-> bus)
        else $error("released bus not recessive");
    dev_hold_a: assert property (dev_start_s |-> dev_oe [*8])
        else $error("device drive too short");
    node_hold_a: assert property (node_start_s |-> node_oe [*8])
        else $error("node drive too short");
    dev_max_a: assert property (dev_run_q <= BREAK_CYC)
        else $error("device drive too long");
    node_len_a: assert property (node_end_s |->
        node_run_q == BREAK_CYC || node_run_q == WAKE_TX_CYC)
        else $error("node drive length wrong");
    node_max_a: assert property (node_run_q <= BREAK_CYC)
        else $error("node drive too long");
endmodule : lsw_sva

//--- hdl/lsw_consts.svh
`ifndef LSW_CONSTS_SVH
`define LSW_CONSTS_SVH

// ============================================================
// Direct register addresses
`define LSW_SFR_CF        8'hc9
`define LSW_SFR_DAT       8'hd2
`define LSW_SFR_ADR       8'hd3

// ============================================================
// Indirect core register indices
`define LSW_CORE_DATA_LAST 8'h07
`define LSW_CORE_CTRL     8'h08
`define LSW_CORE_ST       8'h09
`define LSW_CORE_ERR      8'h0a
`define LSW_CORE_SIZE     8'h0b
`define LSW_CORE_DIV      8'h0c
`define LSW_CORE_MUL      8'h0d
`define LSW_CORE_ID       8'h0e
`define LSW_CORE_COUNT    16

// ============================================================
// Field positions
`define LSW_CF_ON         7
`define LSW_CF_MASTER     6
`define LSW_CF_AUTO       5
`define LSW_CTRL_STOP     7
`define LSW_CTRL_SLEEP    6
`define LSW_CTRL_DIRECTION_SEL     5
`define LSW_CTRL_ACK      4
`define LSW_CTRL_CLRIRQ   3
`define LSW_CTRL_CLRFLT   2
`define LSW_CTRL_WAKE     1
`define LSW_CTRL_GO       0
`define LSW_SIZE_ENH      7

// ============================================================
// Reset values
`define LSW_CF_RESET      8'h60

// ============================================================
// Timing
`define LSW_CLK_MHZ       100
`define LSW_IDLE_MS       4000
`define LSW_WAKE_RESP_MS  150
`define LSW_BREAK_US      650
`define LSW_WAKE_TX_US    250
`define LSW_WAKE_DET_US   150
`define LSW_IDLE_CYC      (`LSW_IDLE_MS * 1000 * `LSW_CLK_MHZ)
`define LSW_WAKE_RESP_CYC (`LSW_WAKE_RESP_MS * 1000 * `LSW_CLK_MHZ)
`define LSW_BREAK_CYC     (`LSW_BREAK_US * `LSW_CLK_MHZ)
`define LSW_WAKE_TX_CYC   (`LSW_WAKE_TX_US * `LSW_CLK_MHZ)
`define LSW_WAKE_DET_CYC  (`LSW_WAKE_DET_US * `LSW_CLK_MHZ)

`endif

//--- hdl/lsw_device.sv
`timescale 1ns/100ps
`include "lsw_consts.svh"

module lsw_device #(
    parameter int unsigned IDLE_CYC      = `LSW_IDLE_CYC,
    parameter int unsigned WAKE_RESP_CYC = `LSW_WAKE_RESP_CYC,
    parameter int unsigned BREAK_CYC     = `LSW_BREAK_CYC,
    parameter int unsigned WAKE_TX_CYC   = `LSW_WAKE_TX_CYC,
    parameter int unsigned WAKE_DET_CYC  = `LSW_WAKE_DET_CYC
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic [7:0]        sfr_addr,
    input  wire logic              sfr_wr,
    input  wire logic              sfr_rd,
    input  wire lsw_pkg::lsw_byte_t sfr_wdata,
    output lsw_pkg::lsw_byte_t     sfr_rdata,
    output logic                   irq,
    lsw_if.dev                     lin
);
    import lsw_pkg::*;

    generate
        if (WAKE_DET_CYC == 0 || BREAK_CYC <= WAKE_DET_CYC ||
            WAKE_TX_CYC < WAKE_DET_CYC || IDLE_CYC == 0 ||
            WAKE_RESP_CYC == 0) begin : g_bad
            $error("lsw_device: timing parameters out of range");
        end
    endgenerate

    function automatic logic core_hit(input logic [7:0] a,
                                      input logic [7:0] idx);
        return a == idx;
    endfunction : core_hit

    // ========================================================
    // Register state
    lsw_state_t  st_q;
    logic        on_q, master_q, auto_q;
    lsw_byte_t   adr_q;
    lsw_byte_t   data_q [8];
    logic        sleep_q, direction_sel_q, ack_q, wake_req_q, go_q;
    logic        enh_q;
    logic [3:0]  cnt_q;
    lsw_byte_t   div_q, mul_q;
    logic [5:0]  id_q;
    logic        idle_q, pend_q, irqf_q, err_q, wake_q, done_q;
    logic [4:0]  fault_q;
    logic [31:0] tmr_q, low_q, idle_cnt_q;
    logic        prev_q;

    // ========================================================
    // Bus decode
    logic wr_cf, wr_adr, wr_dat, wr_ctrl, wr_size;
    logic stop_pulse, clr_irq, clr_flt;
    assign wr_cf   = sfr_wr && sfr_addr == `LSW_SFR_CF;
    assign wr_adr  = sfr_wr && sfr_addr == `LSW_SFR_ADR;
    assign wr_dat  = sfr_wr && sfr_addr == `LSW_SFR_DAT;
    assign wr_ctrl = wr_dat && core_hit(adr_q, `LSW_CORE_CTRL);
    assign wr_size = wr_dat && core_hit(adr_q, `LSW_CORE_SIZE);
    assign stop_pulse = wr_ctrl && sfr_wdata[`LSW_CTRL_STOP];
    assign clr_irq = wr_ctrl && sfr_wdata[`LSW_CTRL_CLRIRQ];
    assign clr_flt = wr_ctrl && sfr_wdata[`LSW_CTRL_CLRFLT];

    // ========================================================
    // Core register view
    lsw_byte_t core_v [`LSW_CORE_COUNT];
    lsw_byte_t cf_v, core_sel, rd_mux;
    logic      active;
    assign active = (st_q != ST_IDLE) && (st_q != ST_STOPPED);
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_data
            assign core_v[gi] = data_q[gi];
        end
    endgenerate
    assign core_v[8]  = {1'b0, sleep_q, direction_sel_q, ack_q,
                         2'b00, wake_req_q, go_q};
    assign core_v[9]  = {active, idle_q, 1'b0, pend_q,
                         irqf_q, err_q, wake_q, done_q};
    assign core_v[10] = {3'b000, fault_q};
    assign core_v[11] = {enh_q, 3'b000, cnt_q};
    assign core_v[12] = div_q;
    assign core_v[13] = mul_q;
    assign core_v[14] = {2'b00, id_q};
    assign core_v[15] = 8'h00;
    assign core_sel = (adr_q <= `LSW_CORE_ID) ? core_v[adr_q[3:0]]
                                              : 8'h00;
    assign cf_v   = {on_q, master_q, auto_q, 5'b00000};
    assign rd_mux = (sfr_addr == `LSW_SFR_CF)  ? cf_v     :
                    (sfr_addr == `LSW_SFR_ADR) ? adr_q    :
                    (sfr_addr == `LSW_SFR_DAT) ? core_sel : 8'h00;

    // ========================================================
    // Bus pulse measurement
    logic bus, drive, rise, brk_ev, wake_ev, bit_ev, fell_other;
    assign bus   = lin.bus;
    assign drive = (st_q == ST_BRK_TX) || (st_q == ST_WAKE_TX);
    assign rise  = on_q && bus && !prev_q && !drive;
    assign brk_ev  = rise && (low_q >= BREAK_CYC);
    assign wake_ev = rise && (low_q >= WAKE_DET_CYC) && !brk_ev &&
                     (st_q != ST_STOPPED);
    assign fell_other = !bus && prev_q && !drive;
    assign bit_ev = drive && bus;

    // ========================================================
    // Reconfiguration, refusal and event terms
    logic reset_if, idle_ev, go_ok, wake_ok, done_ev, timeout_fault_ev;
    logic hdr_ev, ack_use, err_ev;
    assign reset_if = !on_q ||
        (wr_size && active &&
         sfr_wdata[`LSW_SIZE_ENH] != enh_q) ||
        (wr_cf && active &&
         sfr_wdata[`LSW_CF_MASTER] != master_q);
    assign go_ok   = st_q == ST_IDLE && master_q && go_q && !err_q;
    assign wake_ok = st_q == ST_IDLE && wake_req_q && !go_ok &&
                     !err_q;
    assign idle_ev = on_q && !master_q && !sleep_q && bus &&
                     idle_cnt_q == IDLE_CYC - 1;
    assign done_ev = !reset_if && (
        (st_q == ST_BRK_TX && !bit_ev && tmr_q == BREAK_CYC - 1) ||
        (st_q == ST_WAKE_TX && master_q && !bit_ev &&
         tmr_q == WAKE_TX_CYC - 1));
    assign timeout_fault_ev = !reset_if && st_q == ST_WAKE_WAIT &&
                     !fell_other && tmr_q == WAKE_RESP_CYC - 1;
    assign hdr_ev  = !reset_if && !master_q && brk_ev &&
                     (st_q == ST_IDLE || st_q == ST_STOPPED ||
                      st_q == ST_FRAME);
    assign ack_use = st_q == ST_FRAME && ack_q;
    assign err_ev  = !reset_if && (bit_ev || timeout_fault_ev);

    // ========================================================
    // Link state machine
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q  <= ST_IDLE;
            tmr_q <= 32'h0;
        end else if (reset_if || err_ev) begin
            st_q  <= ST_IDLE;
            tmr_q <= 32'h0;
        end else begin
            tmr_q <= tmr_q + 32'h1;
            unique case (st_q)
                ST_IDLE: begin
                    tmr_q <= 32'h0;
                    if (go_ok)
                        st_q <= ST_BRK_TX;
                    else if (wake_ok)
                        st_q <= ST_WAKE_TX;
                    else if (hdr_ev)
                        st_q <= ST_FRAME;
                end
                ST_BRK_TX: begin
                    if (done_ev)
                        st_q <= ST_IDLE;
                end
                ST_WAKE_TX: begin
                    if (tmr_q == WAKE_TX_CYC - 1) begin
                        st_q  <= master_q ? ST_IDLE : ST_WAKE_WAIT;
                        tmr_q <= 32'h0;
                    end
                end
                ST_WAKE_WAIT: begin
                    if (fell_other)
                        st_q <= ST_IDLE;
                end
                ST_STOPPED: begin
                    if (hdr_ev)
                        st_q <= ST_FRAME;
                end
                ST_FRAME: begin
                    if (stop_pulse)
                        st_q <= ST_STOPPED;
                    else if (hdr_ev)
                        st_q <= ST_FRAME;
                    else if (ack_use)
                        st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ========================================================
    // Bus watchers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_q     <= 1'b1;
            low_q      <= 32'h0;
            idle_cnt_q <= 32'h0;
        end else begin
            prev_q <= bus;
            if (bus || drive)
                low_q <= 32'h0;
            else if (low_q != 32'hffffffff)
                low_q <= low_q + 32'h1;
            if (!bus || master_q || sleep_q || !on_q)
                idle_cnt_q <= 32'h0;
            else if (idle_cnt_q != IDLE_CYC)
                idle_cnt_q <= idle_cnt_q + 32'h1;
        end
    end

    // ========================================================
    // Direct and core registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {on_q, master_q, auto_q} <= 3'(`LSW_CF_RESET >> 5);
            adr_q  <= 8'h00;
            sleep_q <= 1'b0;
            direction_sel_q <= 1'b0;
            enh_q  <= 1'b0;
            cnt_q  <= 4'h0;
            div_q  <= 8'h00;
            mul_q  <= 8'h00;
            id_q   <= 6'h00;
            sfr_rdata <= 8'h00;
        end else begin
            if (wr_cf) begin
                on_q     <= sfr_wdata[`LSW_CF_ON];
                master_q <= sfr_wdata[`LSW_CF_MASTER];
                auto_q   <= sfr_wdata[`LSW_CF_AUTO];
            end
            if (wr_adr)
                adr_q <= sfr_wdata;
            if (sfr_rd)
                sfr_rdata <= rd_mux;
            if (wr_ctrl) begin
                sleep_q <= sfr_wdata[`LSW_CTRL_SLEEP];
                direction_sel_q  <= sfr_wdata[`LSW_CTRL_DIRECTION_SEL];
            end
            if (wr_size) begin
                enh_q <= sfr_wdata[`LSW_SIZE_ENH];
                cnt_q <= sfr_wdata[3:0];
            end
            if (wr_dat && core_hit(adr_q, `LSW_CORE_DIV))
                div_q <= sfr_wdata;
            if (wr_dat && core_hit(adr_q, `LSW_CORE_MUL))
                mul_q <= sfr_wdata;
            if (wr_dat && core_hit(adr_q, `LSW_CORE_ID))
                id_q <= sfr_wdata[5:0];
        end
    end

    generate
        for (gi = 0; gi < 8; gi++) begin : g_dreg
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst)
                    data_q[gi] <= 8'h00;
                else if (wr_dat && core_hit(adr_q, 8'(gi)))
                    data_q[gi] <= sfr_wdata;
            end
        end
    endgenerate

    // ========================================================
    // Self-clearing requests and sticky flags, set wins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            wake_req_q <= 1'b0;
            go_q  <= 1'b0;
            {idle_q, pend_q, irqf_q, err_q, wake_q, done_q} <= 6'h00;
            fault_q <= 5'h00;
        end else begin
            ack_q <= wr_ctrl ? sfr_wdata[`LSW_CTRL_ACK] : 1'b0;
            wake_req_q <= wr_ctrl ? sfr_wdata[`LSW_CTRL_WAKE]
                        : wake_req_q && !(st_q == ST_IDLE);
            go_q <= wr_ctrl ? sfr_wdata[`LSW_CTRL_GO]
                  : go_q && !(st_q == ST_IDLE);
            idle_q <= (idle_q && bus) || idle_ev;
            pend_q <= (pend_q && !ack_use && !stop_pulse &&
                       !reset_if) || hdr_ev;
            wake_q <= wake_q || wake_ev;
            done_q <= (done_q && !go_ok && !wake_ok) ||
                      done_ev || wake_ev;
            err_q  <= (err_q && !clr_flt) || err_ev;
            fault_q[2] <= (fault_q[2] && !clr_flt) || timeout_fault_ev;
            fault_q[0] <= (fault_q[0] && !clr_flt) ||
                          (bit_ev && !reset_if);
            fault_q[4:3] <= clr_flt ? 2'b00 : fault_q[4:3];
            fault_q[1]   <= clr_flt ? 1'b0  : fault_q[1];
            irqf_q <= (irqf_q && !clr_irq) || idle_ev || done_ev ||
                      wake_ev || err_ev || hdr_ev;
        end
    end

    // ========================================================
    // Outputs
    assign irq         = irqf_q;
    assign lin.dev_out = 1'b0;
    assign lin.dev_oe  = drive;

endmodule : lsw_device

//--- hdl/lsw_if.sv
`timescale 1ns/100ps

// ============================================================
// Single-wire bus, wired-AND of both ends with recessive high
interface lsw_if;
    logic dev_out;
    logic dev_oe;
    logic node_out;
    logic node_oe;
    logic bus;

    assign bus = !((dev_oe && !dev_out) || (node_oe && !node_out));

    modport dev  (input bus, output dev_out, output dev_oe);
    modport node (input bus, output node_out, output node_oe);
endinterface : lsw_if

//--- hdl/lsw_node.sv
`timescale 1ns/100ps
`include "lsw_consts.svh"

module lsw_node #(
    parameter int unsigned BREAK_CYC    = `LSW_BREAK_CYC,
    parameter int unsigned WAKE_TX_CYC  = `LSW_WAKE_TX_CYC,
    parameter int unsigned WAKE_DET_CYC = `LSW_WAKE_DET_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic send_break,
    input  wire logic send_wake,
    output logic      busy,
    output logic      break_seen,
    output logic      wake_seen,
    lsw_if.node       lin
);
    import lsw_pkg::*;

    generate
        if (WAKE_DET_CYC == 0 || BREAK_CYC <= WAKE_DET_CYC) begin : g_bad
            $error("lsw_node: break must be longer than wake detect");
        end
    endgenerate

    lsw_node_state_t st_q;
    logic [31:0]     len_q;
    logic [31:0]     cnt_q;
    logic [31:0]     low_q;
    logic            prev_q;
    logic            rise;
    logic            is_brk;
    logic            is_wake;

    // ========================================================
    // Pulse measurement of what other nodes drive
    assign rise    = lin.bus && !prev_q && (st_q == NS_IDLE);
    assign is_brk  = rise && (low_q >= BREAK_CYC);
    assign is_wake = rise && (low_q >= WAKE_DET_CYC) && !is_brk;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_q <= 1'b1;
            low_q  <= 32'h0;
        end else begin
            prev_q <= lin.bus;
            if (lin.bus || st_q == NS_DRIVE)
                low_q <= 32'h0;
            else if (low_q != 32'hffffffff)
                low_q <= low_q + 32'h1;
        end
    end

    // ========================================================
    // Dominant pulse generator
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q       <= NS_IDLE;
            len_q      <= 32'h0;
            cnt_q      <= 32'h0;
            break_seen <= 1'b0;
            wake_seen  <= 1'b0;
        end else begin
            break_seen <= is_brk;
            wake_seen  <= is_wake;
            unique case (st_q)
                NS_IDLE: begin
                    cnt_q <= 32'h0;
                    if (send_break) begin
                        st_q  <= NS_DRIVE;
                        len_q <= BREAK_CYC;
                    end else if (send_wake) begin
                        st_q  <= NS_DRIVE;
                        len_q <= WAKE_TX_CYC;
                    end
                end
                NS_DRIVE: begin
                    cnt_q <= cnt_q + 32'h1;
                    if (cnt_q == len_q - 32'h1)
                        st_q <= NS_IDLE;
                end
            endcase
        end
    end

    assign busy         = (st_q == NS_DRIVE);
    assign lin.node_out = 1'b0;
    assign lin.node_oe  = (st_q == NS_DRIVE);

endmodule : lsw_node

//--- hdl/lsw_pkg.sv
package lsw_pkg;

    typedef logic [7:0] lsw_byte_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BRK_TX,
        ST_WAKE_TX,
        ST_WAKE_WAIT,
        ST_STOPPED,
        ST_FRAME
    } lsw_state_t;

    typedef enum logic {
        NS_IDLE,
        NS_DRIVE
    } lsw_node_state_t;

endpackage : lsw_pkg
